// ===== logic/sscs_defs.svh
// Register offsets, field positions and reset values of the serial shift clock select block.
// Included by the package and the design; holds definitions only.
`ifndef SSCS_DEFS_SVH
`define SSCS_DEFS_SVH

// Byte offsets on the register bus
`define SSCS_CTRL_OFS 4'h0
`define SSCS_PP_OFS 4'h4
`define SSCS_DATA_OFS 4'h8
`define SSCS_CNT_OFS 4'hC

// Control register fields
`define SSCS_TC_BIT 0
`define SSCS_CLK_BIT 1
`define SSCS_CS_LSB 2
`define SSCS_CS_MSB 3
`define SSCS_WM_LSB 4
`define SSCS_WM_MSB 5

// Pin position register field
`define SSCS_POS_BIT 0

// Reset values
`define SSCS_CTRL_RST 8'h00
`define SSCS_PP_RST 1'h0
`define SSCS_DATA_RST 8'h00
`define SSCS_CNT_RST 4'h0

// Bus answers
`define SSCS_RESP_OKAY 2'h0
`define SSCS_RESP_SLVERR 2'h2

`endif

// ===== logic/sscs_pkg.sv
// Types shared by the serial shift clock select block.
// Assumes sscs_defs.svh is on the include path.
`include "sscs_defs.svh"

package sscs_pkg;

   // Clock source field encodings
   typedef enum logic [1:0] {
      SSCS_SRC_STROBE = 2'h0,
      SSCS_SRC_TIMER = 2'h1,
      SSCS_SRC_EXT_POS = 2'h2,
      SSCS_SRC_EXT_NEG = 2'h3
   } sscs_src_t;

   // System-domain state
   typedef struct packed {
      logic [7:0] ctrl;
      logic pin_pos;
      logic [7:0] data;
      logic [3:0] cnt;
      logic out_latch;
      logic clk_port;
      logic [2:0] sck_sync;
      logic sck_filt;
      logic [2:0] din_sync;
      logic din_filt;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } sscs_sys_t;

   // Pin drive bundle toward the link domain
   typedef struct packed {
      logic pb_dout;
      logic pb_clk;
      logic pb_clk_oe;
      logic pa_dout;
      logic pa_clk;
      logic pa_clk_oe;
   } sscs_pins_t;

   // Link-domain state
   typedef struct packed {
      sscs_pins_t stage1;
      sscs_pins_t stage2;
   } sscs_link_t;

endpackage : sscs_pkg

// ===== logic/sscs_top.sv
// Clock source selection, shift data register and edge counter of a serial shift port.
// Assumes an AXI4-Lite master on sys_clk and pin drivers retimed on the link clock.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`include "sscs_defs.svh"

// Summary of operation
// - Two-bit field selects shift and counter clock.
// - External clock: output updates on opposite edge.
// - Strobe or timer source: output bypasses latch, latch holds.
// - Field 00: clock only on strobe write.
// - Field 01: timer match clocks both.
// - External: shift on rising or falling edge.
// - External: strobe bit selects counter clock.
// - Strobe shifts and counts; reads zero.
// - Output changes at once; shifts previous input.
// - Toggle write inverts clock port; reads zero.
// - External with select: toggle clocks counter.
// - Pin position bits 7:1 read zero.
// - Position bit routes pins port B/A.
// - Strobe bits write-only; control resets zero.
// - Counter clocked externally whatever wire mode.
module sscs_top import sscs_pkg::*; #(
   parameter int DATA_W = 8,
   parameter int CNT_W = 4
) (
   // System clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Link clock for the pin drivers
   input wire logic link_clk,
   // AXI4-Lite write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [3:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Timer compare-match pulse, same clock
   input wire logic timer_match,
   // Clock pin direction from the port logic
   input wire logic clock_pin_direction_bit,
   // Port B pins
   input wire logic pb_serial_data_in,
   input wire logic pb_serial_clock_pin,
   output logic pb_data_out,
   output logic pb_clock_out,
   output logic pb_clock_oe,
   // Port A pins
   input wire logic pa_serial_data_in,
   input wire logic pa_serial_clock_pin,
   output logic pa_data_out,
   output logic pa_clock_out,
   output logic pa_clock_oe
);

   if (DATA_W != 8 || CNT_W != 4) begin : g_check
      $error("sscs_top serves only an 8-bit data register and a 4-bit counter");
   end

   // Decode: bit 4 marks a mapped offset, low bits a one-hot register select
   function automatic logic [4:0] reg_decode(input logic [3:0] addr);
      logic [4:0] sel;
      sel = 5'h00;
      case (addr)
         `SSCS_CTRL_OFS: sel = 5'h11;
         `SSCS_PP_OFS: sel = 5'h12;
         `SSCS_DATA_OFS: sel = 5'h14;
         `SSCS_CNT_OFS: sel = 5'h18;
         default: sel = 5'h00;
      endcase
      return sel;
   endfunction : reg_decode

   logic [1:0] sys_rst_sync;
   logic sys_rstn;
   logic [1:0] link_rst_sync;
   logic link_rstn;
   sscs_sys_t st;
   sscs_sys_t next_st;
   sscs_link_t lk;
   sscs_link_t next_lk;
   sscs_pins_t pins;
   sscs_src_t src;
   logic wr_go;
   logic rd_go;
   logic [4:0] wsel;
   logic [4:0] rsel;
   logic wr_ctrl;
   logic sw_strobe;
   logic toggle_wr;
   logic wr_data;
   logic wr_cnt;
   logic ext_mode;
   logic count_sel;
   logic edge_agree;
   logic sck_rise;
   logic sck_fall;
   logic shift_en;
   logic cnt_en;
   logic latch_en;
   logic data_out;

   // Reset released through two flops in each domain
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sys_rst_sync <= 2'h0;
      end else begin
         sys_rst_sync <= {sys_rst_sync[0], 1'b1};
      end
   end
   assign sys_rstn = sys_rst_sync[1];

   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         link_rst_sync <= 2'h0;
      end else begin
         link_rst_sync <= {link_rst_sync[0], 1'b1};
      end
   end
   assign link_rstn = link_rst_sync[1];

   // Bus handshakes: address and data taken together
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~st.bvalid;
   assign rd_go = s_axi_arvalid & ~st.rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = ~st.rvalid;
   assign wsel = reg_decode(s_axi_awaddr);
   assign rsel = reg_decode(s_axi_araddr);
   assign wr_ctrl = wr_go & s_axi_wstrb[0] & wsel[0];
   assign wr_data = wr_go & s_axi_wstrb[0] & wsel[2];
   assign wr_cnt = wr_go & s_axi_wstrb[0] & wsel[3];

   // Clock source decode
   assign src = sscs_src_t'(st.ctrl[`SSCS_CS_MSB:`SSCS_CS_LSB]);
   assign ext_mode = st.ctrl[`SSCS_CS_MSB];
   assign count_sel = st.ctrl[`SSCS_CLK_BIT];
   assign sw_strobe = wr_ctrl & s_axi_wdata[`SSCS_CLK_BIT]
      & (s_axi_wdata[`SSCS_CS_MSB:`SSCS_CS_LSB] == SSCS_SRC_STROBE);
   assign toggle_wr = wr_ctrl & s_axi_wdata[`SSCS_TC_BIT];

   // Edge counts once second and third stages agree
   assign edge_agree = st.sck_sync[1] == st.sck_sync[2];
   assign sck_rise = edge_agree & st.sck_sync[2] & ~st.sck_filt;
   assign sck_fall = edge_agree & ~st.sck_sync[2] & st.sck_filt;

   assign shift_en = sw_strobe
      | ((src == SSCS_SRC_TIMER) & timer_match)
      | (ext_mode & (st.ctrl[`SSCS_CS_LSB] ? sck_fall : sck_rise));
   // Wire mode takes no part here, so the pin still counts
   assign cnt_en = sw_strobe
      | ((src == SSCS_SRC_TIMER) & timer_match)
      | (ext_mode & ~count_sel & (sck_rise | sck_fall))
      | (ext_mode & count_sel & toggle_wr);
   assign latch_en = ext_mode & (st.ctrl[`SSCS_CS_LSB] ? sck_rise : sck_fall);

   // Strobe and timer modes bypass the latch
   assign data_out = ext_mode ? st.out_latch : st.data[DATA_W-1];

   always_comb begin
      next_st = st;
      // Pin sampling, selected port first
      next_st.sck_sync = {st.sck_sync[1:0],
         st.pin_pos ? pa_serial_clock_pin : pb_serial_clock_pin};
      next_st.din_sync = {st.din_sync[1:0],
         st.pin_pos ? pa_serial_data_in : pb_serial_data_in};
      if (edge_agree) begin
         next_st.sck_filt = st.sck_sync[2];
      end
      if (st.din_sync[1] == st.din_sync[2]) begin
         next_st.din_filt = st.din_sync[2];
      end
      // Register writes
      if (wr_ctrl) begin
         next_st.ctrl = s_axi_wdata[7:0];
         next_st.ctrl[`SSCS_TC_BIT] = 1'b0;
      end
      if (wr_go & s_axi_wstrb[0] & wsel[1]) begin
         next_st.pin_pos = s_axi_wdata[`SSCS_POS_BIT];
      end
      if (toggle_wr) begin
         next_st.clk_port = ~st.clk_port;
      end
      // Shift takes the input filtered one cycle earlier
      if (wr_data) begin
         next_st.data = s_axi_wdata[7:0];
      end else if (shift_en) begin
         next_st.data = {st.data[DATA_W-2:0], st.din_filt};
      end
      if (wr_cnt) begin
         next_st.cnt = s_axi_wdata[3:0];
      end else if (cnt_en) begin
         next_st.cnt = st.cnt + 4'h1;
      end
      if (latch_en) begin
         next_st.out_latch = st.data[DATA_W-1];
      end
      // Write response
      if (wr_go) begin
         next_st.bvalid = 1'b1;
         next_st.bresp = wsel[4] ? `SSCS_RESP_OKAY : `SSCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // Read answer; strobes and reserved bits read zero
      if (rd_go) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = rsel[4] ? `SSCS_RESP_OKAY : `SSCS_RESP_SLVERR;
         next_st.rdata = 32'h0000_0000;
         if (rsel[0]) begin
            next_st.rdata[7:2] = st.ctrl[7:2];
         end
         if (rsel[1]) begin
            next_st.rdata[0] = st.pin_pos;
         end
         if (rsel[2]) begin
            next_st.rdata[7:0] = st.data;
         end
         if (rsel[3]) begin
            next_st.rdata[3:0] = st.cnt;
         end
      end else if (s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge sys_rstn) begin
      if (!sys_rstn) begin
         st <= '0;
         st.ctrl <= `SSCS_CTRL_RST;
         st.pin_pos <= `SSCS_PP_RST;
         st.data <= `SSCS_DATA_RST;
         st.cnt <= `SSCS_CNT_RST;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = st.rdata;

   // Pin routing by position bit
   always_comb begin
      pins.pb_dout = ~st.pin_pos & data_out;
      pins.pb_clk = ~st.pin_pos & st.clk_port;
      pins.pb_clk_oe = ~st.pin_pos & clock_pin_direction_bit;
      pins.pa_dout = st.pin_pos & data_out;
      pins.pa_clk = st.pin_pos & st.clk_port;
      pins.pa_clk_oe = st.pin_pos & clock_pin_direction_bit;
   end

   // Levels cross into the link domain through two flops
   always_comb begin
      next_lk.stage1 = pins;
      next_lk.stage2 = lk.stage1;
   end

   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         lk <= '0;
      end else begin
         lk <= next_lk;
      end
   end

   assign pb_data_out = lk.stage2.pb_dout;
   assign pb_clock_out = lk.stage2.pb_clk;
   assign pb_clock_oe = lk.stage2.pb_clk_oe;
   assign pa_data_out = lk.stage2.pa_dout;
   assign pa_clock_out = lk.stage2.pa_clk;
   assign pa_clock_oe = lk.stage2.pa_clk_oe;

   // Checks on the system domain
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!sys_rstn);

   sequence s_ctrl_read;
      rd_go && rsel[0];
   endsequence

   sequence s_pp_read;
      rd_go && rsel[1];
   endsequence

   chk_idle_no_clock: assert property (
      (src == SSCS_SRC_STROBE) && !wr_go |=> $stable(st.cnt) && $stable(st.data))
      else $error("Counter or data moved without a source");

   chk_strobe_count: assert property (
      sw_strobe && !wr_cnt |=> st.cnt == 4'($past(st.cnt) + 4'h1))
      else $error("Strobe did not count once");

   chk_timer_count: assert property (
      (src == SSCS_SRC_TIMER) && timer_match && !wr_go
      |=> st.cnt == 4'($past(st.cnt) + 4'h1) && st.data[0] == $past(st.din_filt))
      else $error("Timer match did not shift and count");

   chk_ext_both: assert property (
      ext_mode && !count_sel && (sck_rise || sck_fall) && !wr_go
      |=> st.cnt == 4'($past(st.cnt) + 4'h1))
      else $error("External edge not counted");

   chk_toggle_count: assert property (
      ext_mode && count_sel && toggle_wr && !wr_cnt
      |=> st.cnt == 4'($past(st.cnt) + 4'h1))
      else $error("Toggle write did not clock counter");

   chk_ext_shift: assert property (
      ext_mode && (st.ctrl[`SSCS_CS_LSB] ? sck_fall : sck_rise) && !wr_go
      |=> st.data == {$past(st.data[6:0]), $past(st.din_filt)})
      else $error("External edge did not shift");

   chk_toggle_pin: assert property (
      toggle_wr |=> st.clk_port != $past(st.clk_port))
      else $error("Clock port did not toggle");

   chk_ctrl_strobes: assert property (
      s_ctrl_read |=> s_axi_rvalid && s_axi_rdata[1:0] == 2'h0)
      else $error("Strobe bits read nonzero");

   chk_pp_reserved: assert property (
      s_pp_read |=> s_axi_rvalid && s_axi_rdata[31:1] == 31'h0)
      else $error("Pin position reserved bits nonzero");

   chk_latch_hold: assert property (
      ext_mode && !latch_en && !wr_ctrl && $stable(st.ctrl) |=> $stable(data_out))
      else $error("External output changed off the update edge");

endmodule : sscs_top

// ===== tb/sscs_peer.sv
// External serial peer driving the clock and data pins of either pin position.
// Assumes link_clk runs free; the bench calls frame() for each burst of pulses.
module sscs_peer (
   // Timing reference
   input wire logic link_clk,
   // Pin drive toward the block
   output logic pb_din,
   output logic pb_sck,
   output logic pa_din,
   output logic pa_sck
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      pb_din = 1'b0;
      pb_sck = 1'b0;
      pa_din = 1'b0;
      pa_sck = 1'b0;
   end

   task automatic drive(input logic p, input logic c, input logic d);
      @(posedge link_clk);
      if (p) begin
         pa_sck <= c;
         pa_din <= d;
      end else begin
         pb_sck <= c;
         pb_din <= d;
      end
   endtask : drive

   // Data flips after the rising edge, so the two edges see opposite bits
   task automatic frame(input logic p, input int n, input logic b);
      repeat (n) begin
         drive(p, 1'b0, b);
         drive(p, 1'b1, b);
         drive(p, 1'b1, ~b);
         drive(p, 1'b0, ~b);
      end
      @(posedge link_clk);
   endtask : frame

endmodule : sscs_peer

// ===== tb/testbench.sv
// Self-checking bench: register tasks over AXI4-Lite plus a pin-level serial peer.
// Assumes sscs_defs.svh on the include path and sscs_peer compiled first.
`include "sscs_defs.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic link_clk = 1'b0;
   logic resetn = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic timer_match = 1'b0;
   logic dir = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic pb_din, pb_sck, pa_din, pa_sck;
   // Port B data, clock, enable, then port A
   wire [5:0] pins;
   int failures = 0;
   int checks = 0;

   always #4 sys_clk = ~sys_clk;
   initial begin
      #13;
      forever #62.5 link_clk = ~link_clk;
   end

   sscs_top dut (
      .sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .timer_match(timer_match),
      .clock_pin_direction_bit(dir),
      .pb_serial_data_in(pb_din), .pb_serial_clock_pin(pb_sck),
      .pb_data_out(pins[5]), .pb_clock_out(pins[4]), .pb_clock_oe(pins[3]),
      .pa_serial_data_in(pa_din), .pa_serial_clock_pin(pa_sck),
      .pa_data_out(pins[2]), .pa_clock_out(pins[1]), .pa_clock_oe(pins[0])
   );

   sscs_peer peer (
      .link_clk(link_clk), .pb_din(pb_din), .pb_sck(pb_sck),
      .pa_din(pa_din), .pa_sck(pa_sck)
   );

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      bready <= 1'b1;
      do @(posedge sys_clk); while (!(awready === 1'b1 && wready === 1'b1));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK("bresp", `SSCS_RESP_OKAY, bresp)
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] ex,
                     input logic [1:0] er = `SSCS_RESP_OKAY);
      @(posedge sys_clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      `CHK("rdata", ex, rdata)
      `CHK("rresp", er, rresp)
   endtask : rd

   task automatic tick();
      @(posedge sys_clk);
      timer_match <= 1'b1;
      @(posedge sys_clk);
      timer_match <= 1'b0;
   endtask : tick

   // Pins are retimed on link_clk, so give them a few of its edges
   task automatic pin_chk(input logic [5:0] ex);
      repeat (5) @(posedge link_clk);
      `CHK("pins", ex, pins)
   endtask : pin_chk

   task automatic wrap_up();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up

   // About ten times the expected run
   initial begin
      #200us;
      failures++;
      wrap_up();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(`SSCS_CTRL_OFS, 32'h0);
      rd(`SSCS_CNT_OFS, 32'h0);
      rd(4'h2, 32'h0, `SSCS_RESP_SLVERR);
      wr(`SSCS_PP_OFS, 32'hFF);
      rd(`SSCS_PP_OFS, 32'h1);
      wr(`SSCS_PP_OFS, 32'h0);
      // Pin pulses in strobe mode must not clock; leaves data in high
      peer.frame(1'b0, 1, 1'b0);
      rd(`SSCS_CNT_OFS, 32'h0);
      repeat (8) wr(`SSCS_CTRL_OFS, 32'h2);
      rd(`SSCS_CNT_OFS, 32'h8);
      rd(`SSCS_DATA_OFS, 32'hFF);
      rd(`SSCS_CTRL_OFS, 32'h0);
      wr(`SSCS_CNT_OFS, 32'h0);
      wr(`SSCS_CTRL_OFS, 32'h6);
      repeat (3) tick();
      rd(`SSCS_CNT_OFS, 32'h3);
      wr(`SSCS_DATA_OFS, 32'h0);
      // Wire mode stays off while clocking externally
      wr(`SSCS_CTRL_OFS, 32'h8);
      wr(`SSCS_CNT_OFS, 32'h0);
      peer.frame(1'b0, 3, 1'b1);
      rd(`SSCS_CNT_OFS, 32'h6);
      peer.frame(1'b0, 5, 1'b1);
      rd(`SSCS_DATA_OFS, 32'hFF);
      wr(`SSCS_CTRL_OFS, 32'hC);
      peer.frame(1'b0, 8, 1'b1);
      rd(`SSCS_DATA_OFS, 32'h0);
      wr(`SSCS_CTRL_OFS, 32'hA);
      wr(`SSCS_CNT_OFS, 32'h0);
      peer.frame(1'b0, 2, 1'b1);
      wr(`SSCS_CTRL_OFS, 32'hB);
      rd(`SSCS_CNT_OFS, 32'h1);
      rd(`SSCS_CTRL_OFS, 32'h8);
      dir <= 1'b1;
      pin_chk(6'b011000);
      wr(`SSCS_PP_OFS, 32'h1);
      pin_chk(6'b000011);
      wr(`SSCS_CTRL_OFS, 32'h8);
      wr(`SSCS_CTRL_OFS, 32'h9);
      pin_chk(6'b000001);
      wr(`SSCS_CNT_OFS, 32'h0);
      peer.frame(1'b0, 2, 1'b1);
      peer.frame(1'b1, 1, 1'b1);
      rd(`SSCS_CNT_OFS, 32'h2);
      // Port A selected, clock port low, direction set
      wr(`SSCS_DATA_OFS, 32'hC0);
      wr(`SSCS_CTRL_OFS, 32'h0);
      pin_chk(6'h05);
      // Latch still holds the old bit until an update edge
      wr(`SSCS_CTRL_OFS, 32'h8);
      pin_chk(6'h01);
      peer.frame(1'b1, 1, 1'b1);
      pin_chk(6'h05);
      rd(`SSCS_DATA_OFS, 32'h81);
      rd(`SSCS_CNT_OFS, 32'h4);
      wrap_up();
   end

endmodule : testbench
